// [inc/hdm_pkg.sv]
// constants for the host dma mailbox block
package hdm_pkg;

  // core i/o addresses
  localparam logic [7:0] HDM_ADDR_MB0 = 8'hD0;
  localparam logic [7:0] HDM_ADDR_MB1 = 8'hD1;
  localparam logic [7:0] HDM_ADDR_CTRL = 8'hD2;

  // control register field positions
  localparam int HDM_CTRL_EN0 = 0;
  localparam int HDM_CTRL_MUX0 = 2;
  localparam int HDM_CTRL_REQ0 = 4;
  localparam int HDM_CTRL_WE0 = 6;

  // revision code, value is arbitrary
  localparam logic [7:0] HDM_REV_CODE = 8'h5A;

  // reset values
  localparam logic [1:0] HDM_EN_RST = 2'h0;
  localparam logic [1:0] HDM_MUX_RST = 2'h0;
  localparam logic [1:0] HDM_REQ_RST = 2'h0;
  localparam logic [1:0] HDM_REV_RST = 2'h3;
  localparam logic [7:0] HDM_BYTE_RST = 8'h00;
  localparam logic [3:0] HDM_SYNC_RST = 4'hF;
  localparam logic [7:0] HDM_UNMAPPED = 8'h00;

  // data width and buffer depth
  localparam int HDM_DW = 8;
  localparam int HDM_DEPTH = 2;

endpackage

// [design/hdm_fifo2.sv]
// two-entry valid/ready buffer for one mailbox channel
`timescale 1ns/100ps
`default_nettype none
module hdm_fifo2 import hdm_pkg::*; #(
  parameter int W = HDM_DW
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] mem_r [HDM_DEPTH];
  logic [W-1:0] mem_nxt [HDM_DEPTH];
  logic wp_r;
  logic wp_nxt;
  logic rp_r;
  logic rp_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = in_data;
      wp_nxt = ~wp_r;
    end
    if (pop) begin
      rp_nxt = ~rp_r;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mem_r <= '{default: '0};
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      mem_r <= mem_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule
`default_nettype wire

// [design/hdm_top.sv]
// host dma mailbox: two byte channels between host dma and core
// Functional notes
// R1: core loads the outgoing byte before setting the request bit.
// R2: request output drops on read strobe fall in an acknowledged cycle.
// R3: receive byte driven on host bus while read strobe and ack low.
// R4: host bus released on read strobe rise.
// R5: request bit cleared on read strobe rise, marking completion.
// R6: direction output low while host reads a receive latch.
// R7: core polls request bit; on timeout clears request and enable.
// R8: request bit clears on reset, core zero, strobe rise with ack.
// R9: request output high only when request and enable bits set.
// R10: request output low in reset, ack low, or request bit zero.
// R11: transmit latch captures host data when enabled, ack and write low.
// R12: receive data goes to host only when enabled, ack and read low.
// R13: control bit 7 set loads bit 5 into channel 1 request.
// R14: control bit 6 set loads bit 4 into channel 0 request.
// R15: control bit 7 reads set until first core read of channel 1.
// R16: channel 0 latch holds revision until read; bit 6 shows it.
// R17: control bit 3 muxes channel 1 pins to bus grant/request.
// R18: control bit 2 muxes channel 0 pins to serial and dma functions.
// R19: bits 0,1 enable channels; disabled mailbox request pin floats.
// R20: channel 1 transmit latch serves auxiliary host writes when disabled.
// R21: each channel's two latches share one core address by direction.
// R22: core may clear a request bit anytime, forcing output low.
// R23: request output drops on write strobe fall in acknowledged cycle.
// R24: write strobe rise with ack latches data, clears request bit.
// R25: serial port select blocked while an enabled channel is acked.
// R26: host strobes and acks synchronised with edge detect in core.
`timescale 1ns/100ps
`default_nettype none
module hdm_top import hdm_pkg::*; (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic chan0_ack_n,
  input wire logic chan1_ack_n,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  output logic data_direction_n,
  input wire logic aux_host_write,
  output logic chan0_request_pin_o,
  output logic chan0_request_pin_oe,
  output logic chan1_request_pin_o,
  output logic chan1_request_pin_oe,
  input wire logic serial0_request_to_send_n,
  input wire logic bus_grant_n,
  output logic serial0_clock,
  output logic local_dma0_request_n,
  output logic bus_request_n,
  input wire logic serial_select_raw_n,
  output logic serial_port_select_n
);

  // synchroniser stages: bit0 read, bit1 write, bit2 ack0, bit3 ack1
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  logic [3:0] s1_nxt;
  logic [3:0] s2_nxt;
  logic [3:0] s3_nxt;
  logic [7:0] d1_r;
  logic [7:0] d2_r;
  logic [7:0] d1_nxt;
  logic [7:0] d2_nxt;

  // edge events seen on the settled stages only
  logic rd_rise;
  logic rd_fall;
  logic wr_rise;
  logic wr_fall;
  logic rd_low;
  logic wr_low;
  logic [1:0] ack_low;
  logic [1:0] ack_act;

  // control register state
  logic [1:0] en_r;
  logic [1:0] en_nxt;
  logic [1:0] mux_r;
  logic [1:0] mux_nxt;
  logic [1:0] req_r;
  logic [1:0] req_nxt;
  logic [1:0] rev_r;
  logic [1:0] rev_nxt;
  logic [1:0] busy_r;
  logic [1:0] busy_nxt;
  logic [7:0] rx0_r;
  logic [7:0] rx0_nxt;
  logic [7:0] rx1_r;
  logic [7:0] rx1_nxt;
  logic [7:0] cap0_r;
  logic [7:0] cap0_nxt;
  logic [7:0] cap1_r;
  logic [7:0] cap1_nxt;

  // output registers
  logic [7:0] hdo_r;
  logic [7:0] hdo_nxt;
  logic hoe_r;
  logic hoe_nxt;
  logic ddir_r;
  logic ddir_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // buffer hookup
  logic [1:0] push;
  logic [1:0] room;
  logic [1:0] pop;
  logic [1:0] head_vld;
  logic [7:0] head0;
  logic [7:0] head1;
  logic [7:0] push1_data;

  logic wr_ctrl;
  logic we_any;
  logic [1:0] rd_sel;
  logic [1:0] req_drive;

  // synchroniser group
  always_comb begin
    s1_nxt = {chan1_ack_n, chan0_ack_n, host_write_strobe_n, host_read_strobe_n};
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    d1_nxt = host_data_in;
    d2_nxt = d1_r;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= HDM_SYNC_RST;
      s2_r <= HDM_SYNC_RST;
      s3_r <= HDM_SYNC_RST;
      d1_r <= HDM_BYTE_RST;
      d2_r <= HDM_BYTE_RST;
    end else begin
      s1_r <= s1_nxt; // R26
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      d1_r <= d1_nxt;
      d2_r <= d2_nxt;
    end
  end

  // edge detect never looks at the first stage
  assign rd_low = ~s2_r[0];
  assign wr_low = ~s2_r[1];
  assign rd_rise = s2_r[0] & ~s3_r[0]; // R26
  assign rd_fall = ~s2_r[0] & s3_r[0];
  assign wr_rise = s2_r[1] & ~s3_r[1];
  assign wr_fall = ~s2_r[1] & s3_r[1];
  assign ack_low = ~s2_r[3:2];
  // an ack pin muxed to another function is not a mailbox ack
  assign ack_act = ack_low & ~mux_r; // R17 R18

  assign wr_ctrl = io_wr && (io_addr == HDM_ADDR_CTRL);
  assign we_any = io_wdata[HDM_CTRL_WE0] | io_wdata[HDM_CTRL_WE0 + 1];

  // control group
  always_comb begin
    en_nxt = en_r;
    mux_nxt = mux_r;
    req_nxt = req_r;
    rev_nxt = rev_r;
    busy_nxt = busy_r;
    rx0_nxt = rx0_r;
    rx1_nxt = rx1_r;
    cap0_nxt = cap0_r;
    cap1_nxt = cap1_r;
    for (int c = 0; c < 2; c++) begin
      if (ack_act[c] && (rd_rise || wr_rise)) begin
        req_nxt[c] = 1'b0; // R5 R8 R24
        busy_nxt[c] = 1'b0;
      end else if (ack_act[c] && (rd_fall || wr_fall)) begin
        busy_nxt[c] = 1'b1; // R2 R23
      end
      if (!ack_act[c]) begin
        busy_nxt[c] = 1'b0;
      end
      // core write last: its value wins over a same-cycle hardware clear
      if (wr_ctrl && io_wdata[HDM_CTRL_WE0 + c]) begin
        req_nxt[c] = io_wdata[HDM_CTRL_REQ0 + c]; // R13 R14 R22
      end
    end
    if (wr_ctrl && !we_any) begin
      en_nxt = io_wdata[HDM_CTRL_EN0 +: 2]; // R13 R14 R19
      mux_nxt = io_wdata[HDM_CTRL_MUX0 +: 2]; // R17 R18
    end
    if (io_rd && (io_addr == HDM_ADDR_MB0)) begin
      rev_nxt[0] = 1'b0; // R16
    end
    if (io_rd && (io_addr == HDM_ADDR_MB1)) begin
      rev_nxt[1] = 1'b0; // R15
    end
    if (io_wr && (io_addr == HDM_ADDR_MB0)) begin
      rx0_nxt = io_wdata; // R21
    end
    if (io_wr && (io_addr == HDM_ADDR_MB1)) begin
      rx1_nxt = io_wdata; // R21
    end
    if (en_r[0] && ack_act[0] && wr_low) begin
      cap0_nxt = d2_r; // R11
    end
    if (en_r[1] && ack_act[1] && wr_low) begin
      cap1_nxt = d2_r; // R11
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      en_r <= HDM_EN_RST;
      mux_r <= HDM_MUX_RST;
      req_r <= HDM_REQ_RST;
      rev_r <= HDM_REV_RST;
      busy_r <= 2'h0;
      rx0_r <= HDM_BYTE_RST;
      rx1_r <= HDM_BYTE_RST;
      cap0_r <= HDM_BYTE_RST;
      cap1_r <= HDM_BYTE_RST;
    end else begin
      en_r <= en_nxt;
      mux_r <= mux_nxt;
      req_r <= req_nxt;
      rev_r <= rev_nxt;
      busy_r <= busy_nxt;
      rx0_r <= rx0_nxt;
      rx1_r <= rx1_nxt;
      cap0_r <= cap0_nxt;
      cap1_r <= cap1_nxt;
    end
  end

  // host writes go through a buffer so a slow core loses no mailbox byte; auxiliary writes to a full buffer drop
  assign push[0] = en_r[0] & ack_act[0] & wr_rise; // R24
  // disabled channel 1 still takes auxiliary host output writes
  assign push[1] = (en_r[1] & ack_act[1] & wr_rise) | (~en_r[1] & aux_host_write); // R20
  assign push1_data = en_r[1] ? cap1_r : host_data_in;
  // revision read leaves the channel 0 buffer alone
  assign pop[0] = io_rd && (io_addr == HDM_ADDR_MB0) && !rev_r[0] && head_vld[0];
  assign pop[1] = io_rd && (io_addr == HDM_ADDR_MB1) && head_vld[1];

  hdm_fifo2 #(
    .W(HDM_DW)
  ) u_buf0 (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(push[0]),
    .in_ready(room[0]),
    .in_data(cap0_r),
    .out_valid(head_vld[0]),
    .out_ready(pop[0]),
    .out_data(head0)
  );

  hdm_fifo2 #(
    .W(HDM_DW)
  ) u_buf1 (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(push[1]),
    .in_ready(room[1]),
    .in_data(push1_data),
    .out_valid(head_vld[1]),
    .out_ready(pop[1]),
    .out_data(head1)
  );

  // request held off while the buffer is full: that is the back-pressure
  assign req_drive = req_r & en_r & ~ack_low & ~busy_r & room; // R9 R10 R22

  // output group
  always_comb begin
    rd_sel = ack_act & en_r & {rd_low, rd_low}; // R12
    hoe_nxt = |rd_sel; // R3 R4
    hdo_nxt = rd_sel[0] ? rx0_r : rx1_r; // R3
    ddir_nxt = ~(|rd_sel); // R6
    rdata_nxt = rdata_r;
    if (io_rd) begin
      case (io_addr)
        HDM_ADDR_MB0: rdata_nxt = rev_r[0] ? HDM_REV_CODE : head0; // R16 R21
        HDM_ADDR_MB1: rdata_nxt = head1; // R21
        HDM_ADDR_CTRL: rdata_nxt = {rev_r, req_r, mux_r, en_r}; // R15 R16
        default: rdata_nxt = HDM_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hdo_r <= HDM_BYTE_RST;
      hoe_r <= 1'b0;
      ddir_r <= 1'b1;
      rdata_r <= HDM_BYTE_RST;
    end else begin
      hdo_r <= hdo_nxt;
      hoe_r <= hoe_nxt;
      ddir_r <= ddir_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign host_data_out = hdo_r;
  assign host_data_oe = hoe_r;
  assign data_direction_n = ddir_r;
  assign io_rdata = rdata_r;

  // pin multiplexing; a disabled mailbox pin floats
  assign chan0_request_pin_o = mux_r[0] ? serial0_request_to_send_n : req_drive[0]; // R18
  assign chan0_request_pin_oe = mux_r[0] | en_r[0]; // R19
  assign chan1_request_pin_o = mux_r[1] ? bus_grant_n : req_drive[1]; // R17
  assign chan1_request_pin_oe = mux_r[1] | en_r[1]; // R19

  // ack pins feed the alternate functions only when muxed there
  assign serial0_clock = mux_r[0] & chan0_ack_n; // R18
  assign local_dma0_request_n = ~mux_r[0] | chan0_ack_n;
  assign bus_request_n = ~mux_r[1] | chan1_ack_n; // R17

  assign serial_port_select_n = serial_select_raw_n | (|(ack_act & en_r)); // R25

endmodule
`default_nettype wire

// [verif/hdm_monitor.sv]
// assertion checker for the host dma mailbox top
`timescale 1ns/100ps
`default_nettype none
module hdm_monitor import hdm_pkg::*; (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] io_addr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic host_read_strobe_n,
  input wire logic chan0_ack_n,
  input wire logic chan1_ack_n,
  input wire logic host_data_oe,
  input wire logic data_direction_n,
  input wire logic chan0_request_pin_o,
  input wire logic chan0_request_pin_oe,
  input wire logic chan1_request_pin_oe,
  input wire logic serial0_request_to_send_n,
  input wire logic bus_request_n,
  input wire logic serial_select_raw_n,
  input wire logic serial_port_select_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // acks pass a two-flop sync, so hold them long enough to settle
  sequence ack0_held;
    !chan0_ack_n [*4];
  endsequence
  sequence acks_idle;
    (chan0_ack_n && chan1_ack_n) [*4];
  endsequence
  AST_REQ_LOW_ACK: assert property (ack0_held ##0 chan0_request_pin_o |-> serial0_request_to_send_n)
    else $error("request pin high during ack");
  AST_OE_DIR: assert property (host_data_oe |->
    !data_direction_n && !$past(host_read_strobe_n, 3))
    else $error("bus driven without direction low");
  AST_OE_CAUSE: assert property ($rose(host_data_oe) |->
    !$past(host_read_strobe_n, 2) && (!$past(chan0_ack_n, 2) || !$past(chan1_ack_n, 2)))
    else $error("bus driven without read and ack");
  AST_OE_RELEASE: assert property ($rose(host_read_strobe_n) |-> ##[1:5] !host_data_oe)
    else $error("bus not released after read");
  AST_SEL_BLOCK: assert property (!serial_port_select_n |-> !serial_select_raw_n)
    else $error("select asserted without raw select");
  AST_SEL_PASS: assert property (acks_idle |-> serial_port_select_n == serial_select_raw_n)
    else $error("select not passed through");
  AST_FWD_BUS_REQUEST_N: assert property (!bus_request_n |-> !chan1_ack_n)
    else $error("bus request without ack pin low");
  AST_RST_HIZ: assert property ($rose(reset_n) |-> !chan0_request_pin_oe && !chan1_request_pin_oe)
    else $error("request pin driven after reset");
  AST_UNMAPPED: assert property (io_rd && io_addr > HDM_ADDR_CTRL |=> io_rdata == HDM_UNMAPPED)
    else $error("unmapped read not zero");
endmodule
bind hdm_top hdm_monitor u_mon (.mclk, .reset_n, .io_addr, .io_rd, .io_rdata,
  .host_read_strobe_n, .chan0_ack_n, .chan1_ack_n, .host_data_oe, .data_direction_n,
  .chan0_request_pin_o, .chan0_request_pin_oe, .chan1_request_pin_oe,
  .serial0_request_to_send_n, .bus_request_n, .serial_select_raw_n, .serial_port_select_n);
`default_nettype wire

// [verif/hdm_host_model.sv]
// host dma controller model: acks, strobes and host data
`timescale 1ns/100ps
`default_nettype none
module hdm_host_model (
  input wire logic mclk,
  output logic rd_n,
  output logic wr_n,
  output logic [1:0] ack_n,
  output logic aux,
  output logic [7:0] data
);
  logic [7:0] last;
  initial begin
    rd_n = 1'b1;
    wr_n = 1'b1;
    ack_n = 2'h3;
    aux = 1'b0;
    data = 8'hFF;
    last = 8'h00;
  end
  task automatic start(input int ch, input logic wr, input logic [7:0] d);
    @(posedge mclk);
    ack_n[ch] <= 1'b0;
    data <= d;
    last = d;
    repeat (3) @(posedge mclk);
    if (wr) wr_n <= 1'b0;
    else rd_n <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  // released bus shows the inverse, never a stale byte
  task automatic finish_cycle(input int ch);
    @(posedge mclk);
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (4) @(posedge mclk);
    ack_n[ch] <= 1'b1;
    data <= ~last;
    repeat (4) @(posedge mclk);
  endtask
  task automatic aux_write(input logic [7:0] d);
    @(posedge mclk);
    data <= d;
    aux <= 1'b1;
    @(posedge mclk);
    aux <= 1'b0;
    repeat (2) @(posedge mclk);
    data <= ~d;
  endtask
endmodule
`default_nettype wire

// [verif/hdm_top_test.sv]
// self-checking bench for the host dma mailbox
`timescale 1ns/100ps
`default_nettype none
module hdm_top_test;
  import hdm_pkg::*;
  typedef struct packed {logic [7:0] w; logic [7:0] r; logic [1:0] oe;} hdm_row_s;
  hdm_row_s rows [8] = '{'{8'h03, 8'h03, 2'h3}, '{8'h0C, 8'h0C, 2'h3}, '{8'h50, 8'h1C, 2'h3},
    '{8'hA0, 8'h3C, 2'h3}, '{8'h4F, 8'h2C, 2'h3}, '{8'h80, 8'h0C, 2'h3},
    '{8'h30, 8'h00, 2'h0}, '{8'h01, 8'h01, 2'h1}};
  logic mclk, reset_n, io_wr, io_rd, rts_n, grant_n, raw_n;
  logic oe, ddir, p0, p0e, p1, p1e, sclk, dreq_n, breq_n, sel_n;
  logic [7:0] io_addr, io_wdata, io_rdata, hdo, rd;
  wire logic rdn, wrn, aux;
  wire logic [1:0] ackn;
  wire logic [7:0] hdi;
  int fail_count, checks, n;
  hdm_host_model host (.mclk(mclk), .rd_n(rdn), .wr_n(wrn), .ack_n(ackn), .aux(aux), .data(hdi));
  hdm_top dut (.mclk(mclk), .reset_n(reset_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .host_read_strobe_n(rdn),
    .host_write_strobe_n(wrn), .chan0_ack_n(ackn[0]), .chan1_ack_n(ackn[1]),
    .host_data_in(hdi), .host_data_out(hdo), .host_data_oe(oe), .data_direction_n(ddir),
    .aux_host_write(aux), .chan0_request_pin_o(p0), .chan0_request_pin_oe(p0e),
    .chan1_request_pin_o(p1), .chan1_request_pin_oe(p1e), .serial0_request_to_send_n(rts_n),
    .bus_grant_n(grant_n), .serial0_clock(sclk), .local_dma0_request_n(dreq_n),
    .bus_request_n(breq_n), .serial_select_raw_n(raw_n), .serial_port_select_n(sel_n));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge mclk);
    io_wr <= 1'b0;
    #1;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge mclk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge mclk);
    io_rd <= 1'b0;
    @(posedge mclk);
    #1 rd = io_rdata;
  endtask
  task automatic give_verdict;
    $display("errors %0d in %0d checks", fail_count, checks);
    if (fail_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // whole run is a few hundred cycles
  initial begin
    #2000000;
    fail_count++;
    give_verdict();
  end
  initial begin
    {reset_n, io_wr, io_rd, rts_n, raw_n, io_addr, io_wdata} = '0;
    grant_n = 1'b1;
    raw_n = 1'b1;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    rdr(HDM_ADDR_CTRL); check(rd, 8'hC0);
    rdr(HDM_ADDR_MB0); check(rd, HDM_REV_CODE);
    rdr(HDM_ADDR_CTRL); check(rd, 8'h80);
    rdr(HDM_ADDR_MB1);
    rdr(HDM_ADDR_CTRL); check(rd, 8'h00);
    wr(8'hD5, 8'hFF);
    rdr(8'hD5); check(rd, HDM_UNMAPPED);
    foreach (rows[i]) begin
      wr(HDM_ADDR_CTRL, rows[i].w);
      rdr(HDM_ADDR_CTRL); check(rd, rows[i].r);
      check({p1e, p0e}, rows[i].oe);
    end
    // muxed pins: alternate functions, mailbox ignores the host
    wr(HDM_ADDR_CTRL, 8'h0C);
    rts_n <= 1'b1;
    grant_n <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      host.start(c, 1'b0, 8'h00);
      #1 check(oe, 1'b0);
      check(c ? breq_n : dreq_n, 1'b0);
      check(sclk, c[0]);
      check({p1, p0}, 2'h1);
      host.finish_cycle(c);
    end
    rts_n <= 1'b0;
    grant_n <= 1'b1;
    wr(HDM_ADDR_CTRL, 8'h01);
    wr(HDM_ADDR_MB0, 8'hA5);
    wr(HDM_ADDR_CTRL, 8'h50);
    check(p0, 1'b1);
    raw_n <= 1'b0;
    host.start(0, 1'b0, 8'h00);
    #1 check(p0, 1'b0);
    check({oe, ddir}, 2'h2);
    check(hdo, 8'hA5);
    check(sel_n, 1'b1);
    rdr(HDM_ADDR_CTRL); check(rd, 8'h11);
    host.finish_cycle(0);
    #1 check({oe, ddir}, 2'h1);
    rdr(HDM_ADDR_CTRL); check(rd, 8'h01);
    check(sel_n, 1'b0);
    raw_n <= 1'b1;
    wr(HDM_ADDR_CTRL, 8'h00);
    host.start(0, 1'b0, 8'h00);
    #1 check({oe, ddir}, 2'h1);
    host.finish_cycle(0);
    wr(HDM_ADDR_CTRL, 8'h02);
    wr(HDM_ADDR_CTRL, 8'hA0);
    check(p1, 1'b1);
    host.start(1, 1'b1, 8'h3C);
    #1 check(p1, 1'b0);
    rdr(HDM_ADDR_CTRL); check(rd, 8'h22);
    host.finish_cycle(1);
    n = 0;
    do begin
      rdr(HDM_ADDR_CTRL);
      n++;
    end while (rd[5] !== 1'b0 && n < 20);
    check(rd, 8'h02);
    rdr(HDM_ADDR_MB1); check(rd, 8'h3C);
    // core stalls: two bytes fill the buffer, request then held back
    for (int k = 0; k < 2; k++) begin
      wr(HDM_ADDR_CTRL, 8'hA0);
      host.start(1, 1'b1, k ? 8'h22 : 8'h11);
      host.finish_cycle(1);
    end
    wr(HDM_ADDR_CTRL, 8'hA0);
    check(p1, 1'b0);
    rdr(HDM_ADDR_MB1); check(rd, 8'h11);
    check(p1, 1'b1);
    rdr(HDM_ADDR_MB1); check(rd, 8'h22);
    wr(HDM_ADDR_CTRL, 8'h80);
    check(p1, 1'b0);
    wr(HDM_ADDR_CTRL, 8'h00);
    host.aux_write(8'h77);
    rdr(HDM_ADDR_MB1); check(rd, 8'h77);
    // mid-run reset with a request pending
    wr(HDM_ADDR_CTRL, 8'h50);
    reset_n <= 1'b0;
    #1 check({oe, ddir, p1e, p0e}, 8'h04);
    check(io_rdata, HDM_BYTE_RST);
    @(posedge mclk);
    reset_n <= 1'b1;
    rdr(HDM_ADDR_CTRL); check(rd, 8'hC0);
    give_verdict();
  end
endmodule
`default_nettype wire
